// ===== hdl/chk_accum.sv
// modulo-64 ones counter that builds the sector check character
module chk_accum (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [5:0] chr,
  output logic [5:0] sum
);
  logic [5:0] sum_r;
  logic [5:0] sum_nxt;

  // six-bit sum wraps by itself, which is the remainder by 64
  always_comb
  begin
    sum_nxt = sum_r;
    if (clr)
      sum_nxt = 6'h0;
    else if (en)
      sum_nxt = 6'(sum_r + 6'($countones(chr)));
  end

  // running count
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      sum_r <= 6'h0;
    else
      sum_r <= sum_nxt;
  end

  assign sum = sum_r;
endmodule

// ===== hdl/disc_seq.sv
// disc sector addressing and on-line/off-line sequencer of the disc controller
// ==========================================
// Overview of operation
// R1 - sector holds 240 data characters, passed through with no format check
// R2 - on writes the check character is appended as character 241
// R3 - check character is the count of one bits modulo 64
// R4 - ordinary buffer read delivers only the 240 data characters
// R5 - check character readable after buffer address set then buffer read
// R6 - sectors number continuously; 32 sectors reachable per actuator position
// R7 - zone 00 inner both surfaces, 01 outer top, 10 outer bottom, 11 illegal
// R8 - execution ends after the sector whose five low bits are all ones
// R9 - diagnostic sectors at address zero are not blocked
// R10 - fast discs are 12 to 15 for option one, 8 to 15 for option two
// R11 - processor zeroes actuator position bits on fast discs
// R12 - characters four to six are interpreted per command
// R13 - processor seeks before reading or writing a unit
// R14 - disc data goes into the buffer before reaching the processor
// R15 - off-line portion starts together with not busy
// R16 - control character error skips off-line, sets status, signals not busy
// R17 - finishing off-line raises the special interrupt
// R18 - processor then asks that unit for its status
// R19 - other instructions run unless they need a committed unit; code also refuses every combined instruction while the off-line portion runs
// R20 - combined instructions except seek commit the buffer until off-line ends
// R21 - plain seek leaves the buffer uncommitted
// R22 - combined instruction goes busy, takes six characters into the unit block
// R23 - end of transfer before six characters flags invalid control character
// R24 - address comes from three six-bit characters: sector, position, zone, disc
`include "disc_seq_regs.svh"
module disc_seq (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire disc_seq_pkg::chan_in_t chan_in,
  output disc_seq_pkg::chan_out_t chan_out,
  input wire disc_seq_pkg::disc_in_t disc_in,
  output disc_seq_pkg::disc_out_t disc_out
);
  import disc_seq_pkg::*;

  st_t st_r;
  st_t st_nxt;
  logic [5:0] buf_mem [0:1023];
  logic mem_we;
  logic [9:0] mem_wa;
  logic [5:0] mem_wd;
  logic [35:0] cc_new;
  logic [17:0] addr_new;
  logic cc_done;
  logic fcmd;
  logic need_buf;
  logic bad;
  logic refuse;
  logic sect_end;
  logic gen_clr;
  logic gen_en;
  logic [5:0] gen_char;
  logic [5:0] gen_sum;
  logic [9:0] disc_ba;
  logic [1:0] reg_ui;
  logic [1:0] zone;
  logic [3:0] disc;

  // check character generator, cleared at the start of every sector
  chk_accum u_chk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clr(gen_clr),
    .en(gen_en),
    .chr(gen_char),
    .sum(gen_sum)
  );

  // next-state logic for bus, on-line and off-line engines
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.not_busy = 1'b0;
    st_nxt.spi = 1'b0;
    st_nxt.rd_valid = 1'b0;
    st_nxt.rdata = 8'h00;
    mem_we = 1'b0;
    mem_wa = st_r.bptr;
    mem_wd = chan_in.chr;
    gen_clr = 1'b0;
    gen_en = 1'b0;
    gen_char = buf_mem[{st_r.blk, st_r.idx}];
    sect_end = 1'b0;
    disc_ba = {st_r.blk, st_r.idx};
    reg_ui = 2'(reg_addr - `REG_UST0);
    cc_new = {st_r.cc[29:0], chan_in.chr};
    addr_new = cc_new[`ADDR_LSB +: 18];
    cc_done = st_r.on == ON_CHARS && chan_in.char_valid && st_r.ccnt == `CC_LAST;
    fcmd = st_r.cmd inside {CMD_SEEK, CMD_SREAD, CMD_SWRITE};
    need_buf = st_r.cmd inside {CMD_SREAD, CMD_SWRITE};
    // R7 illegal zone is a control character error
    bad = st_r.unit_bad || addr_new[`ZONE_LSB +: 2] == `ZONE_BAD;
    // single disc port, so a busy off-line engine also refuses
    refuse = st_r.ucommit[st_r.unit] || (need_buf && st_r.bcommit) || st_r.off != OFF_IDLE;

    // register bus: writes first so hardware status sets below win
    if (reg_wr)
    begin
      if (reg_addr == `REG_CTRL)
        st_nxt.fa_opt = reg_wdata[1:0];
      else if (reg_addr == `REG_STAT)
        st_nxt.cstat = st_r.cstat & ~reg_wdata[7:4];
      else if (reg_addr >= `REG_UST0 && reg_addr <= `REG_UST3)
        st_nxt.ustat[reg_ui] = st_r.ustat[reg_ui] & ~reg_wdata[3:0];
    end
    if (reg_rd)
    begin
      if (reg_addr == `REG_CTRL)
        st_nxt.rdata = {6'h00, st_r.fa_opt};
      else if (reg_addr == `REG_STAT)
        st_nxt.rdata = {st_r.cstat, st_r.ucommit};
      else if (reg_addr >= `REG_UST0 && reg_addr <= `REG_UST3)
        st_nxt.rdata = {st_r.ucommit[reg_ui], st_r.bcommit, 2'h0, st_r.ustat[reg_ui]};
    end

    // on-line engine: command intake and buffer traffic with the channel
    case (st_r.on)
      ON_IDLE:
      begin
        if (chan_in.cmd_valid)
        begin
          st_nxt.cmd = chan_in.cmd;
          st_nxt.unit = 2'(chan_in.unit - 3'h1);
          st_nxt.unit_bad = chan_in.unit == 3'h0 || chan_in.unit > 3'h4;
          st_nxt.ccnt = 3'h0;
          st_nxt.cc = 36'h0_0000_0000;
          case (chan_in.cmd)
            CMD_STAT:
            begin
              // R18 per-unit outcome returned as one character
              st_nxt.rd_valid = 1'b1;
              st_nxt.rd_char = {1'b0, st_r.ucommit[st_nxt.unit], st_r.ustat[st_nxt.unit]};
              st_nxt.not_busy = 1'b1;
            end
            CMD_RBUF, CMD_WBUF:
            begin
              // R19 buffer traffic refused only while the buffer is committed
              if (st_r.bcommit)
              begin
                st_nxt.cstat[`ST_REF] = 1'b1;
                st_nxt.not_busy = 1'b1;
              end
              else
                st_nxt.on = chan_in.cmd == CMD_RBUF ? ON_BUFR : ON_BUFW;
            end
            CMD_NONE:
              st_nxt.not_busy = 1'b1;
            default:
              st_nxt.on = ON_CHARS; // R22
          endcase
        end
      end
      ON_CHARS:
      begin
        if (chan_in.char_valid)
        begin
          st_nxt.cc = cc_new;
          st_nxt.ccnt = 3'(st_r.ccnt + 3'h1);
        end
        if (cc_done)
        begin
          st_nxt.on = ON_IDLE;
          st_nxt.not_busy = 1'b1;
          if (st_r.cmd == CMD_BADDR)
          begin
            st_nxt.bptr = cc_new[`BUF_LSB +: 10]; // R5
            st_nxt.baddr_set = 1'b1;
          end
          else if (st_r.unit_bad)
            st_nxt.cstat[`ST_CTL] = 1'b1; // R16
          else if (bad)
            st_nxt.ustat[st_r.unit][`ST_CTL] = 1'b1; // R16
          else if (refuse)
            st_nxt.ustat[st_r.unit][`ST_REF] = 1'b1; // R19
          else if (fcmd)
          begin
            // R22 chars land in the unit block; R15 off-line starts with not busy
            st_nxt.bcb[st_r.unit] = cc_new;
            st_nxt.ustat[st_r.unit] = 4'h0;
            st_nxt.ounit = st_r.unit;
            st_nxt.owrite = st_r.cmd == CMD_SWRITE;
            st_nxt.oseek = st_r.cmd == CMD_SEEK;
            st_nxt.oaddr = addr_new[16:0]; // R24 R9 R6
            st_nxt.nleft = cc_new[`CNT_LSB +: 2]; // R12
            st_nxt.blk = 2'h0;
            st_nxt.idx = 8'h00;
            st_nxt.off = OFF_SEEK;
            st_nxt.seek_req = 1'b1;
            st_nxt.ucommit[st_r.unit] = 1'b1;
            st_nxt.bcommit = need_buf; // R20 R21
            gen_clr = 1'b1;
          end
        end
        else if (chan_in.end_xfer)
        begin
          // R23 short control sequence
          st_nxt.on = ON_IDLE;
          st_nxt.not_busy = 1'b1;
          if (st_r.unit_bad || st_r.cmd == CMD_BADDR)
            st_nxt.cstat[`ST_CTL] = 1'b1;
          else
            st_nxt.ustat[st_r.unit][`ST_CTL] = 1'b1;
        end
      end
      ON_BUFR:
      begin
        // R14 processor only ever sees data through the buffer
        if (chan_in.end_xfer ||
            st_r.bptr[7:0] >= (st_r.baddr_set ? `CHECK_IDX : `DATA_LAST))
        begin
          st_nxt.on = ON_IDLE;
          st_nxt.not_busy = 1'b1;
          st_nxt.baddr_set = 1'b0;
          st_nxt.bptr = {2'(st_r.bptr[9:8] + 2'h1), 8'h00};
        end
        else
          st_nxt.bptr = 10'(st_r.bptr + 10'h001);
        if (!chan_in.end_xfer)
        begin
          st_nxt.rd_valid = 1'b1; // R4 R5
          st_nxt.rd_char = buf_mem[st_r.bptr];
        end
      end
      ON_BUFW:
      begin
        st_nxt.baddr_set = 1'b0;
        if (chan_in.char_valid && !chan_in.end_xfer)
        begin
          mem_we = 1'b1; // R1
          st_nxt.bptr = 10'(st_r.bptr + 10'h001);
        end
        if (chan_in.end_xfer || (chan_in.char_valid && st_r.bptr[7:0] >= `DATA_LAST))
        begin
          st_nxt.on = ON_IDLE;
          st_nxt.not_busy = 1'b1;
          st_nxt.bptr = {2'(st_r.bptr[9:8] + 2'h1), 8'h00};
        end
      end
      default:
        st_nxt.on = ON_IDLE;
    endcase

    // off-line engine: seek, sector transfer, completion
    case (st_r.off)
      OFF_IDLE:
        st_nxt.xfer = 1'b0;
      OFF_SEEK:
      begin
        if (disc_in.seek_done)
        begin
          st_nxt.seek_req = 1'b0;
          st_nxt.off = st_r.oseek ? OFF_DONE : OFF_XFER;
          st_nxt.xfer = !st_r.oseek;
        end
      end
      OFF_XFER:
      begin
        if (st_r.owrite)
        begin
          if (!st_r.wr_valid || disc_in.wr_ready)
          begin
            if (st_r.idx <= `CHECK_IDX)
            begin
              // R2 R3 check character follows the 240th data character
              st_nxt.wr_valid = 1'b1;
              st_nxt.wr_char = st_r.idx == `CHECK_IDX ? gen_sum : gen_char;
              gen_en = st_r.idx != `CHECK_IDX;
              st_nxt.idx = 8'(st_r.idx + 8'h01);
            end
            else
            begin
              st_nxt.wr_valid = 1'b0;
              sect_end = 1'b1;
            end
          end
        end
        else if (disc_in.rd_valid)
        begin
          // R14 disc characters go to the buffer, check char kept at 240
          mem_we = 1'b1;
          mem_wa = disc_ba;
          mem_wd = disc_in.rd_char;
          gen_char = disc_in.rd_char;
          st_nxt.idx = 8'(st_r.idx + 8'h01);
          if (st_r.idx != `CHECK_IDX)
            gen_en = 1'b1; // R3
          else
          begin
            if (disc_in.rd_char != gen_sum)
              st_nxt.ustat[st_r.ounit][`ST_CHK] = 1'b1;
            sect_end = 1'b1;
          end
        end
        if (sect_end)
        begin
          // R8 never run past the last sector of the actuator position
          if (st_r.oaddr[`SECT_LSB +: 5] == `LAST_SECT || st_r.nleft == 2'h0)
          begin
            st_nxt.off = OFF_DONE;
            st_nxt.xfer = 1'b0;
          end
          else
          begin
            st_nxt.oaddr[`SECT_LSB +: 5] = 5'(st_r.oaddr[`SECT_LSB +: 5] + 5'h01);
            st_nxt.blk = 2'(st_r.blk + 2'h1);
            st_nxt.nleft = 2'(st_r.nleft - 2'h1);
            st_nxt.idx = 8'h00;
            gen_clr = 1'b1;
          end
        end
      end
      OFF_DONE:
      begin
        // R17 interrupt and release of commitments in the same edge
        st_nxt.spi = 1'b1;
        st_nxt.ucommit[st_r.ounit] = 1'b0;
        st_nxt.bcommit = 1'b0; // R20
        st_nxt.ustat[st_r.ounit][`ST_DONE] = 1'b1;
        st_nxt.off = OFF_IDLE;
      end
      default:
        st_nxt.off = OFF_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.fa_opt <= `CTRL_RST;
    end
    else
      st_r <= st_nxt;
  end

  // buffer storage, no reset needed for data
  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      buf_mem[mem_wa] <= mem_wd;
  end

  // outputs straight from the state register
  assign zone = st_r.oaddr[`ZONE_LSB +: 2];
  assign disc = st_r.oaddr[`DISC_LSB +: 4];
  assign reg_rdata = st_r.rdata;
  assign chan_out.busy = st_r.on != ON_IDLE;
  assign chan_out.not_busy = st_r.not_busy;
  assign chan_out.spi = st_r.spi;
  assign chan_out.rd_valid = st_r.rd_valid;
  assign chan_out.rd_char = st_r.rd_char;
  assign disc_out.seek_req = st_r.seek_req;
  assign disc_out.xfer = st_r.xfer;
  assign disc_out.write = st_r.owrite;
  assign disc_out.unit = st_r.ounit;
  assign disc_out.disc = disc;
  assign disc_out.pos = st_r.oaddr[`POS_LSB +: 6];
  assign disc_out.sector = st_r.oaddr[`SECT_LSB +: 5];
  // zone decode; 11 never reaches the disc since it is flagged as a control character error
  assign disc_out.inner = zone == 2'h0; // R7
  assign disc_out.top = zone == 2'h0 || zone == 2'h1; // R7
  assign disc_out.bottom = zone == 2'h0 || zone == 2'h2; // R7
  assign disc_out.fast = (st_r.fa_opt == 2'h1 && disc >= `FA1_MIN) ||
                         (st_r.fa_opt == 2'h2 && disc >= `FA2_MIN); // R10
  assign disc_out.wr_valid = st_r.wr_valid;
  assign disc_out.wr_char = st_r.wr_char;

  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  six_chars_a: assert property (cc_done |=> chan_out.not_busy && st_r.on == ON_IDLE)
    else $error("six characters did not end the on-line portion"); // R22
  short_ctl_a: assert property (st_r.on == ON_CHARS && chan_in.end_xfer && !chan_in.char_valid
      |=> chan_out.not_busy && (st_r.cstat[`ST_CTL] || st_r.ustat[$past(st_r.unit)][`ST_CTL]))
    else $error("short control sequence not flagged"); // R23
  ctl_err_skip_a: assert property (cc_done && bad && st_r.off == OFF_IDLE
      |=> st_r.off == OFF_IDLE && chan_out.not_busy)
    else $error("off-line started despite control error"); // R16
  offline_start_a: assert property (st_r.off == OFF_IDLE ##1 st_r.off == OFF_SEEK
      |-> chan_out.not_busy && disc_out.seek_req)
    else $error("off-line began without not busy"); // R15
  done_irq_a: assert property (st_r.off == OFF_DONE
      |=> chan_out.spi && !st_r.ucommit[$past(st_r.ounit)])
    else $error("completion without special interrupt"); // R17
  check_char_a: assert property (disc_out.wr_valid && st_r.idx == 8'hf1
      |-> disc_out.wr_char == gen_sum)
    else $error("check character is not the ones count"); // R3
  plain_read_a: assert property (chan_out.rd_valid && !$past(st_r.baddr_set)
      && $past(st_r.on) == ON_BUFR |-> $past(st_r.bptr[7:0]) < `CHECK_IDX)
    else $error("ordinary read delivered the check character"); // R4
  buf_commit_a: assert property (st_r.off != OFF_IDLE && !st_r.oseek |-> st_r.bcommit)
    else $error("buffer not committed during transfer"); // R20
  seek_free_a: assert property (st_r.off != OFF_IDLE && st_r.oseek |-> !st_r.bcommit)
    else $error("plain seek committed the buffer"); // R21
  last_sector_a: assert property (sect_end && disc_out.sector == `LAST_SECT
      |=> st_r.off == OFF_DONE)
    else $error("transfer ran past the last sector"); // R8
  unit_refuse_a: assert property (cc_done && !bad && st_r.cmd != CMD_BADDR
      && st_r.ucommit[st_r.unit] |=> st_r.ustat[$past(st_r.unit)][`ST_REF]
      && st_r.ounit == $past(st_r.ounit))
    else $error("committed unit was reused"); // R19
  fast_disc_a: assert property (disc_out.fast |-> disc >= `FA2_MIN)
    else $error("fast access below disc 8"); // R10

  write_done_c: cover property (st_r.off == OFF_DONE && st_r.owrite);
  read_done_c: cover property (st_r.off == OFF_DONE && !st_r.owrite && !st_r.oseek);
  seek_done_c: cover property (st_r.off == OFF_DONE && st_r.oseek);
  check_read_c: cover property (chan_out.rd_valid && $past(st_r.baddr_set));
endmodule

// ===== hdl/disc_seq_pkg.sv
// types shared by the disc sequencer and its bench
package disc_seq_pkg;
  typedef enum logic [2:0] {
    CMD_STAT = 3'h0, CMD_SEEK = 3'h1, CMD_SREAD = 3'h2, CMD_SWRITE = 3'h3,
    CMD_BADDR = 3'h4, CMD_RBUF = 3'h5, CMD_WBUF = 3'h6, CMD_NONE = 3'h7
  } cmd_t;
  typedef enum logic [1:0] {
    ON_IDLE = 2'h0, ON_CHARS = 2'h1, ON_BUFW = 2'h3, ON_BUFR = 2'h2
  } on_st_t;
  typedef enum logic [1:0] {
    OFF_IDLE = 2'h0, OFF_SEEK = 2'h1, OFF_XFER = 2'h3, OFF_DONE = 2'h2
  } off_st_t;
  typedef struct packed {
    logic cmd_valid; cmd_t cmd; logic [2:0] unit;
    logic char_valid; logic [5:0] chr; logic end_xfer;
  } chan_in_t;
  typedef struct packed {
    logic busy; logic not_busy; logic spi; logic rd_valid; logic [5:0] rd_char;
  } chan_out_t;
  typedef struct packed {
    logic seek_done; logic wr_ready; logic rd_valid; logic [5:0] rd_char;
  } disc_in_t;
  typedef struct packed {
    logic seek_req; logic xfer; logic write; logic [1:0] unit; logic [3:0] disc;
    logic inner; logic top; logic bottom; logic fast; logic [5:0] pos;
    logic [4:0] sector; logic wr_valid; logic [5:0] wr_char;
  } disc_out_t;
  typedef struct packed {
    on_st_t on; off_st_t off; cmd_t cmd; logic [1:0] unit; logic unit_bad;
    logic [2:0] ccnt; logic [35:0] cc; logic [3:0][35:0] bcb; logic [1:0] fa_opt;
    logic [3:0] ucommit; logic bcommit; logic [3:0][3:0] ustat; logic [3:0] cstat;
    logic [1:0] ounit; logic owrite; logic oseek; logic [16:0] oaddr;
    logic [1:0] nleft; logic [1:0] blk; logic [7:0] idx; logic [9:0] bptr;
    logic baddr_set; logic not_busy; logic spi; logic rd_valid; logic [5:0] rd_char;
    logic seek_req; logic xfer; logic wr_valid; logic [5:0] wr_char; logic [7:0] rdata;
  } st_t;
endpackage

// ===== hdl/disc_seq_regs.svh
// register offsets, address field positions and fixed counts of the disc sequencer
`ifndef DISC_SEQ_REGS_SVH
`define DISC_SEQ_REGS_SVH
// ==========================================
// register offsets
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define REG_UST0 4'h2
`define REG_UST3 4'h5
// ==========================================
// reset values
`define CTRL_RST 2'h0
// ==========================================
// sector address fields inside the 18-bit address
`define SECT_LSB 0
`define POS_LSB 5
`define ZONE_LSB 11
`define DISC_LSB 13
// control character slices inside the 36-bit staging word
`define ADDR_LSB 18
`define CNT_LSB 12
`define BUF_LSB 24
// ==========================================
// counts and codes
`define CC_LAST 3'h5
`define DATA_LAST 8'hef
`define CHECK_IDX 8'hf0
`define LAST_SECT 5'h1f
`define ZONE_BAD 2'h3
`define FA1_MIN 4'hc
`define FA2_MIN 4'h8
// unit and controller status bit positions
`define ST_DONE 0
`define ST_CHK 1
`define ST_CTL 2
`define ST_REF 3
`endif

// ===== tb/disc_model.sv
// disc drive model facing the sequencer's disc port
module disc_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire disc_seq_pkg::disc_out_t dout,
  output disc_seq_pkg::disc_in_t din,
  output logic [5:0] wr_last,
  output int nrd,
  output int nwr
);
  import disc_seq_pkg::*;
  int wait_n;
  int idx;
  logic [5:0] acc;
  // ==========================================
  // seek delay, sector read stream, write acceptance
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      din <= '0;
      wait_n <= 0;
      idx <= 0;
      acc <= 6'h00;
      nrd <= 0;
      nwr <= 0;
      wr_last <= 6'h00;
    end
    else
    begin
      din.seek_done <= 1'b0;
      din.rd_valid <= 1'b0;
      din.rd_char <= ~din.rd_char;  // idle line never keeps the last character
      din.wr_ready <= ~din.wr_ready;  // half rate, so held characters are exercised
      // slow seek, long enough to read status while the unit is committed
      if (dout.seek_req && !din.seek_done)
      begin
        wait_n <= wait_n + 1;
        if (wait_n == 30)
        begin
          din.seek_done <= 1'b1;
          wait_n <= 0;
        end
      end
      // 240 data characters, the ones count mod 64, then one idle cycle
      if (!dout.xfer || dout.write || idx == 241)
      begin
        idx <= 0;
        acc <= 6'h00;
      end
      else
      begin
        din.rd_valid <= 1'b1;
        din.rd_char <= (idx == 240) ? acc : (6'(idx) ^ 6'h15);
        acc <= acc + 6'($countones(6'(idx) ^ 6'h15));
        idx <= idx + 1;
        nrd <= nrd + 1;
      end
      if (dout.wr_valid && din.wr_ready)
      begin
        wr_last <= dout.wr_char;
        nwr <= nwr + 1;
      end
    end
  end
endmodule

// ===== tb/disc_seq_bench.sv
// self-checking bench of the disc sequencer
module disc_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import disc_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  chan_in_t ci = '0;
  chan_out_t co;
  disc_in_t di;
  disc_out_t dout;
  logic [5:0] wr_last;
  int nrd, nwr;
  int fails = 0;
  int checks = 0;
  logic [5:0] got [$];
  // ==========================================
  // design, disc drive and clock
  disc_seq uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_in(ci), .chan_out(co), .disc_in(di), .disc_out(dout));
  disc_model dm (.sys_clk(sys_clk), .rst_n(rst_n), .dout(dout), .din(di),
    .wr_last(wr_last), .nrd(nrd), .nwr(nwr));
  always #12.5 sys_clk = ~sys_clk;
  // characters handed back to the channel
  always @(posedge sys_clk)
    if (co.rd_valid === 1'b1)
      got.push_back(co.rd_char);
  // ==========================================
  // access tasks
  function automatic logic [5:0] csum(input logic [5:0] x);
    csum = 6'h00;
    for (int i = 0; i < 240; i++)
      csum += 6'($countones(6'(i) ^ x));
  endfunction
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    cmp(reg_rdata, e);
  endtask
  // bounded wait for not busy or the special interrupt
  task automatic await(input bit spi);
    int n;
    n = 0;
    @(negedge sys_clk);
    while ((spi ? co.spi : co.not_busy) !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 3000)
      fails++;
  endtask
  task automatic cmd(input cmd_t c, input logic [2:0] u);
    @(posedge sys_clk);
    ci.cmd_valid <= 1'b1;
    ci.cmd <= c;
    ci.unit <= u;
    @(posedge sys_clk);
    ci.cmd_valid <= 1'b0;
  endtask
  // control characters, first one most significant; short count ends the transfer
  task automatic chars(input logic [17:0] a, input logic [5:0] c4, input int n);
    logic [35:0] w;
    w = {a, c4, 12'h000};
    for (int i = 0; i < n; i++)
    begin
      ci.char_valid <= 1'b1;
      ci.chr <= w[35 - 6 * i -: 6];
      @(posedge sys_clk);
    end
    ci.char_valid <= 1'b0;
    if (n < 6)
    begin
      ci.end_xfer <= 1'b1;
      @(posedge sys_clk);
      ci.end_xfer <= 1'b0;
    end
  endtask
  task automatic wbuf(input logic [5:0] x);
    for (int i = 0; i < 240; i++)
    begin
      ci.char_valid <= 1'b1;
      ci.chr <= 6'(i) ^ x;
      @(posedge sys_clk);
    end
    ci.char_valid <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // test sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    // seek/read of a last-in-run sector with four requested: disc 3, outer top
    cmd(CMD_SREAD, 3'h1);
    chars({1'b0, 4'h3, 2'b01, 6'h08, 5'h1f}, 6'h03, 6);
    await(0);
    cmp({dout.inner, dout.top, dout.bottom, dout.fast, dout.disc}, 8'h43);
    cmp({co.busy, dout.seek_req, 1'b0, dout.sector}, 8'h5f);
    rd(4'h2, 8'hc0);
    cmd(CMD_RBUF, 3'h0);
    await(0);
    rd(4'h1, 8'h81);
    wr(4'h1, 8'hf0);
    await(1);
    cmp(8'(nrd), 8'hf1);
    rd(4'h2, 8'h01);
    // status command answers with one character on the channel
    cmd(CMD_STAT, 3'h1);
    repeat (2) @(negedge sys_clk);
    cmp({2'b00, got[0]}, 8'h01);
    got.delete();
    cmd(CMD_RBUF, 3'h0);
    await(0);
    @(negedge sys_clk);
    cmp(8'(got.size()), 8'hf0);
    for (int i = 0; i < 240; i++)
      cmp({2'b00, got[i]}, {2'b00, 6'(i) ^ 6'h15});
    // buffer address 240 exposes the stored check character
    cmd(CMD_BADDR, 3'h0);
    chars({12'd240, 6'h00}, 6'h00, 6);
    await(0);
    got.delete();
    cmd(CMD_RBUF, 3'h0);
    await(0);
    @(negedge sys_clk);
    cmp(8'(got.size()), 8'h01);
    cmp({2'b00, got[0]}, {2'b00, csum(6'h15)});
    // write all 64 codes through sector 0 of unit 2, fast option 1 on disc 12
    wr(4'h0, 8'h01);
    cmd(CMD_BADDR, 3'h0);
    chars(18'h0, 6'h00, 6);
    await(0);
    cmd(CMD_WBUF, 3'h0);
    wbuf(6'h2a);
    await(0);
    cmd(CMD_SWRITE, 3'h2);
    chars({1'b0, 4'hc, 2'b10, 6'h00, 5'h00}, 6'h00, 6);
    await(0);
    cmp({dout.inner, dout.top, dout.bottom, dout.fast, dout.disc}, 8'h3c);
    await(1);
    cmp(8'(nwr), 8'hf1);
    cmp({2'b00, wr_last}, {2'b00, csum(6'h2a)});
    rd(4'h3, 8'h01);
    // illegal zone on unit 3: no seek, status only
    cmd(CMD_SREAD, 3'h3);
    chars({1'b0, 4'h1, 2'b11, 6'h00, 5'h02}, 6'h00, 6);
    await(0);
    cmp({7'h00, dout.seek_req}, 8'h00);
    rd(4'h4, 8'h04);
    // transfer ended after three characters
    cmd(CMD_SEEK, 3'h4);
    chars(18'h0, 6'h00, 3);
    await(0);
    rd(4'h5, 8'h04);
    // controller-only device code lands the flag in the controller status
    cmd(CMD_SEEK, 3'h0);
    chars(18'h0, 6'h00, 2);
    await(0);
    rd(4'h1, 8'h40);
    wr(4'h1, 8'hf0);
    rd(4'h1, 8'h00);
    // plain seek, fast option 2 on disc 8, inner zone
    wr(4'h0, 8'h02);
    rd(4'h0, 8'h02);
    wr(4'h2, 8'h0f);
    cmd(CMD_SEEK, 3'h1);
    chars({1'b0, 4'h8, 2'b00, 6'h00, 5'h04}, 6'h00, 6);
    await(0);
    cmp({dout.inner, dout.top, dout.bottom, dout.fast, dout.disc}, 8'hf8);
    rd(4'h2, 8'h80);
    // second seek to the committed unit is refused, the running one goes on
    cmd(CMD_SEEK, 3'h1);
    chars({1'b0, 4'h8, 2'b00, 6'h00, 5'h04}, 6'h00, 6);
    await(0);
    rd(4'h2, 8'h88);
    await(1);
    rd(4'h2, 8'h09);
    end_of_test();
  end
  // watchdog well beyond the fewer than two thousand cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end
endmodule
